/* File: logic/dtrp_trace_ctrl.sv */
// Trigger, interrupt priority and reset behaviour of the trace debug module.
// Assumes a core that reports fetches, pipe top, pending interrupts and
// change-of-flow, and a host that reads results over AXI4-Lite.
// Contract
// - Opcode trigger loses to coincident pending interrupt.
// - Fetch trigger in end run still detected.
// - End coincident case: disarm, skip interrupt entry.
// - Begin fetch trigger stores interrupt change-of-flow.
// - Begin run stays armed until buffer full.
// - Stays armed until eight words stored.
// - Module never requests a system reset.
// - End-run reset clears arm, flag, break enable.
// - End-run reset keeps other controls and trace.
// - Other resets load default begin run.
// - Default comparator A is 0xFFFE.
// - Default main control is 0xC0.
// - Default trigger control is 0x40.
// - Module drives no interrupt request.
`timescale 1ns/1ps
// The guard in the constants header makes this second inclusion harmless.
`include "dtrp_consts.svh"
module dtrp_trace_ctrl
  import dtrp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  input wire dtrp_core_t core,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic break_request,
  output logic mcu_reset_request,
  output logic cpu_irq
);
  // ----------------------------------------------------------------------
  // Control state.
  // ----------------------------------------------------------------------
  logic [7:0] debug_main_control_q; // Enable, arm, tag, break enable.
  logic [7:0] debug_trigger_control_q; // Opcode qualify and begin select.
  logic [7:0] comparator_a_high_byte_q; // Comparator A high byte.
  logic [7:0] comparator_a_low_byte_q; // Comparator A low byte.
  logic trace_armed_flag_q; // Set while a run is armed.
  logic triggered_q; // Begin run has seen its trigger.
  logic [15:0] fifo_q [`DTRP_FIFO_DEPTH]; // Trace storage.
  logic [3:0] cnt_q; // Valid word count.
  logic [15:0] prev_addr_q; // Address of the previous cycle.
  logic break_q; // Break towards the core.
  logic por_meta_q, por_s2_q, por_s3_q; // Power-on pin synchroniser.
  // ----------------------------------------------------------------------
  // Decoded run type and trigger detection.
  // ----------------------------------------------------------------------
  // Run-type decode is kept combinational; it follows the registers directly.
  logic en, armed, opcode_qualify_select, begin_run, cmp_hit;
  logic trig_fetch, trig_opcode, trigger, store_en, fifo_full;
  logic [15:0] cmp_a, store_val;
  assign en = debug_main_control_q[`DTRP_MAIN_EN];
  assign armed = debug_main_control_q[`DTRP_MAIN_ARM] & en;
  assign opcode_qualify_select = debug_trigger_control_q[`DTRP_TRIG_OPQ];
  assign begin_run = debug_trigger_control_q[`DTRP_TRIG_BEGIN];
  assign cmp_a = {comparator_a_high_byte_q, comparator_a_low_byte_q};
  assign fifo_full = (cnt_q == 4'(`DTRP_FIFO_DEPTH));
  // Both trigger kinds compare against comparator A only; a fetch match needs
  // a valid fetch strobe, so an idle core can never trigger.
  // Fetch trigger ignores the pending interrupt entirely.
  assign trig_fetch = !opcode_qualify_select & core.fetch_valid
                      & (core.fetch_addr == cmp_a);
  // The interrupt wins at the pipe top, so no trigger is seen.
  assign trig_opcode = opcode_qualify_select & core.pipe_top_valid
                       & (core.pipe_top_addr == cmp_a) & !core.irq_pending;
  assign trigger = armed & !triggered_q & (trig_fetch | trig_opcode);
  assign cmp_hit = trig_fetch | trig_opcode;
  // End run stores until trigger, but the trigger cycle's interrupt entry
  // is skipped by the trigger-and-interrupt gate in store_en; begin run stores from trigger on.
  assign store_en = armed & (core.cof != 2'h0) & !fifo_full
                    & (begin_run ? (triggered_q | trigger)
                                 : !(trigger & core.irq_pending));
  // A taken branch stores its source, the previous address minus two;
  // a jump, return or vector stores the current address directly.
  assign store_val = core.cof[1] ? core.cur_addr : 16'(prev_addr_q - 16'h0002);
  // ----------------------------------------------------------------------
  // Power-on pin synchroniser; the second and third stage must agree.
  // ----------------------------------------------------------------------
  // The power-on pin is asynchronous to the bus clock, so its level is only
  // trusted once two later stages agree; a glitch shorter than a cycle is lost.
  always_ff @(posedge aclk) begin
    por_meta_q <= por_n;
    por_s2_q <= por_meta_q;
    por_s3_q <= por_s2_q;
  end
  logic por_seen;
  assign por_seen = !por_s2_q & !por_s3_q;
  // Limitation: a power-on pulse shorter than two bus cycles can be missed, and
  // an armed end run would then be kept instead of replaced.
  // Full reset unless an end run was set up and no power-on happened.
  logic keep_end_run;
  assign keep_end_run = en & !begin_run & !por_seen;
  // ----------------------------------------------------------------------
  // AXI4-Lite handshakes.
  // ----------------------------------------------------------------------
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic aw_have_q, w_have_q, wr_go, rd_go;
  assign wr_go = aw_have_q & w_have_q & !s_axi_bvalid;
  assign rd_go = s_axi_arvalid & s_axi_arready;
  // Address and data are taken independently and joined for the write.
  // Both readies stay low from the take until the response issues, so a
  // second write cannot overtake the first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_q <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                              {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (wr_go) begin
        w_have_q <= 1'b0;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // Write response one cycle after both halves are held.
  // Only the five register words answer OKAY; anything else gets SLVERR.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `DTRP_OFF_MAIN) | (a == `DTRP_OFF_TRIG) | (a == `DTRP_OFF_CMPA)
           | (a == `DTRP_OFF_STAT) | (a == `DTRP_OFF_FIFO);
  endfunction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DTRP_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(aw_q) ? `DTRP_RESP_OKAY : `DTRP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // Read data registered one cycle after the address is taken.
  // A trace read while armed returns the oldest word and leaves the storage
  // in place, so no word is lost to an early host.
  logic fifo_pop;
  assign fifo_pop = rd_go & (s_axi_araddr == `DTRP_OFF_FIFO) & !armed
                    & !trace_armed_flag_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `DTRP_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? `DTRP_RESP_OKAY : `DTRP_RESP_SLVERR;
      case (s_axi_araddr)
        `DTRP_OFF_MAIN: s_axi_rdata <= {24'h000000, debug_main_control_q};
        `DTRP_OFF_TRIG: s_axi_rdata <= {24'h000000, debug_trigger_control_q};
        `DTRP_OFF_CMPA: s_axi_rdata <= {16'h0000, cmp_a};
        // Bit 4 is reserved and reads zero.
        `DTRP_OFF_STAT: s_axi_rdata <= {23'h000000, triggered_q, trace_armed_flag_q,
                                        cmp_hit, break_q, 1'b0, cnt_q};
        `DTRP_OFF_FIFO: s_axi_rdata <= {16'h0000, fifo_q[0]};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  // ----------------------------------------------------------------------
  // Control registers: reset behaviour, software writes, disarm.
  // ----------------------------------------------------------------------
  logic wr_main, wr_trig, wr_cmpa, disarm;
  assign wr_main = wr_go & (aw_q == `DTRP_OFF_MAIN);
  assign wr_trig = wr_go & (aw_q == `DTRP_OFF_TRIG);
  assign wr_cmpa = wr_go & (aw_q == `DTRP_OFF_CMPA);
  // A software write to the main control wins over a disarm in the same cycle.
  // End run disarms on trigger; begin run once eight words are held.
  assign disarm = (trigger & !begin_run)
                | (triggered_q & fifo_full);
  // On an end-run reset the main control keeps all but arm and break enable; the host can then read
  // the trigger setup, comparator and trace as they stood.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      if (keep_end_run) begin
        // Only the arm and break enable bits drop; the rest survives.
        debug_main_control_q[`DTRP_MAIN_ARM] <= 1'b0;
        debug_main_control_q[`DTRP_MAIN_BRK] <= 1'b0;
      end else begin
        debug_main_control_q <= `DTRP_RST_MAIN;
        debug_trigger_control_q <= `DTRP_RST_TRIG;
        comparator_a_high_byte_q <= `DTRP_RST_CAH;
        comparator_a_low_byte_q <= `DTRP_RST_CAL;
      end
    end else begin
      if (wr_main) begin
        debug_main_control_q <= w_q[7:0];
      end else if (disarm) begin
        debug_main_control_q[`DTRP_MAIN_ARM] <= 1'b0;
      end
      if (wr_trig) begin
        debug_trigger_control_q <= w_q[7:0];
      end
      if (wr_cmpa) begin
        comparator_a_high_byte_q <= w_q[15:8];
        comparator_a_low_byte_q <= w_q[7:0];
      end
    end
  end
  // Arm flag, begin-trigger latch and break output.
  // The break is a single-cycle pulse two edges after the disarm event; the
  // core must latch it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trace_armed_flag_q <= keep_end_run ? 1'b0 : 1'b1;
      triggered_q <= 1'b0;
      break_q <= 1'b0;
    end else begin
      if (wr_main) begin
        trace_armed_flag_q <= w_q[`DTRP_MAIN_ARM] & w_q[`DTRP_MAIN_EN];
        triggered_q <= 1'b0;
      end else if (disarm) begin
        trace_armed_flag_q <= 1'b0;
        triggered_q <= 1'b0;
      end else if (trigger & begin_run) begin
        triggered_q <= 1'b1;
      end
      // A begin run breaks only on a full buffer, never at its trigger.
      break_q <= debug_main_control_q[`DTRP_MAIN_BRK] & disarm;
    end
  end
  // ----------------------------------------------------------------------
  // Trace storage; kept across an end-run reset.
  // ----------------------------------------------------------------------
  // The count is not lowered by host reads, so it still tells how many words
  // the run left behind.
  always_ff @(posedge aclk) begin
    prev_addr_q <= core.cur_addr;
    if (!aresetn) begin
      if (!keep_end_run) begin
        cnt_q <= 4'h0;
      end
    end else if (wr_main & w_q[`DTRP_MAIN_ARM]) begin
      cnt_q <= 4'h0;
    end else if (store_en) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  // Words enter at the count index; a host read shifts towards index zero.
  // The top index refills with zero as the words move down.
  generate
    for (genvar i = 0; i < `DTRP_FIFO_DEPTH; i++) begin : g_fifo
      always_ff @(posedge aclk) begin
        if (aresetn & store_en & (cnt_q == 4'(i))) begin
          fifo_q[i] <= store_val;
        end else if (aresetn & fifo_pop) begin
          fifo_q[i] <= (i == `DTRP_FIFO_DEPTH - 1) ? 16'h0000 : fifo_q[(i + 1) % 8];
        end
      end
    end
  endgenerate
  // ----------------------------------------------------------------------
  // Outputs towards the system.
  // ----------------------------------------------------------------------
  // Both request lines are tied low through a flop so that every output of
  // the block still leaves from a register.
  always_ff @(posedge aclk) begin
    mcu_reset_request <= 1'b0;
    cpu_irq <= 1'b0;
    break_request <= aresetn & break_q;
  end
  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  opcode_irq_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (armed & opcode_qualify_select & core.irq_pending) |-> !trigger)
    else $error("Opcode trigger taken during pending interrupt.");
  end_fetch_trig_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (armed & !begin_run & !opcode_qualify_select & core.fetch_valid
     & core.fetch_addr == cmp_a) |=> !debug_main_control_q[`DTRP_MAIN_ARM])
    else $error("End run fetch trigger did not disarm.");
  end_skip_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (trigger & !begin_run & core.irq_pending) |=> $stable(cnt_q))
    else $error("Interrupt entry stored at end trigger.");
  begin_irq_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (trigger & begin_run & core.cof != 2'h0 & !fifo_full) |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("Begin trigger change-of-flow not stored.");
  begin_stay_armed_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (triggered_q & !fifo_full & !wr_main) |=> debug_main_control_q[`DTRP_MAIN_ARM] & !break_q)
    else $error("Begin run disarmed before full.");
  eight_words_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (triggered_q & cnt_q == 4'h8 & !wr_main) |=> !trace_armed_flag_q)
    else $error("Run stayed armed after eight words.");
  // The request flops are unknown until the first clock edge, so even these
  // constant checks wait for reset to be released.
  no_reset_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !mcu_reset_request)
    else $error("Reset request driven.");
  no_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !cpu_irq)
    else $error("Interrupt request driven.");
  end_reset_keep_a: assert property (@(posedge aclk)
    (!aresetn & keep_end_run) |=> !trace_armed_flag_q
      & debug_main_control_q[`DTRP_MAIN_EN] & !debug_main_control_q[`DTRP_MAIN_BRK])
    else $error("End-run reset handling wrong.");
  default_run_a: assert property (@(posedge aclk)
    (!aresetn & !keep_end_run) |=> debug_main_control_q == `DTRP_RST_MAIN
      & debug_trigger_control_q == `DTRP_RST_TRIG & cmp_a == 16'hFFFE)
    else $error("Default begin run not loaded.");
  // An end-run reset must leave the count and the trigger setup untouched.
  end_reset_trace_a: assert property (@(posedge aclk)
    (!aresetn & keep_end_run) |=> cnt_q == $past(cnt_q)
      & debug_trigger_control_q == $past(debug_trigger_control_q))
    else $error("End-run reset lost trace state.");
  // An end trigger with break enabled halts the core two edges later.
  end_trig_break_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (trigger & !begin_run & debug_main_control_q[`DTRP_MAIN_BRK]) |=> ##1 break_request)
    else $error("End trigger break missing.");
  // A begin run with break enabled halts the core once the buffer is full.
  full_break_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (triggered_q & fifo_full & debug_main_control_q[`DTRP_MAIN_BRK]) |=> ##1 break_request)
    else $error("Full buffer break missing.");
endmodule

/* File: logic/dtrp_consts.svh */
// Offsets, field positions, reset values and counts for the trace debug priority block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef DTRP_CONSTS_SVH
`define DTRP_CONSTS_SVH
// ----------------------------------------------------------------------
// Register byte addresses on the AXI4-Lite slave.
// ----------------------------------------------------------------------
`define DTRP_OFF_MAIN 8'h00
`define DTRP_OFF_TRIG 8'h04
`define DTRP_OFF_CMPA 8'h08
`define DTRP_OFF_STAT 8'h0C
`define DTRP_OFF_FIFO 8'h10
// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define DTRP_MAIN_EN 7
`define DTRP_MAIN_ARM 6
`define DTRP_MAIN_TAG 5
`define DTRP_MAIN_BRK 4
`define DTRP_TRIG_OPQ 7
`define DTRP_TRIG_BEGIN 6
// ----------------------------------------------------------------------
// Default begin run loaded by reset; trace depth and bus response codes.
// ----------------------------------------------------------------------
`define DTRP_RST_MAIN 8'hC0
`define DTRP_RST_TRIG 8'h40
`define DTRP_RST_CAH 8'hFF
`define DTRP_RST_CAL 8'hFE
`define DTRP_FIFO_DEPTH 8
`define DTRP_RESP_OKAY 2'h0
`define DTRP_RESP_SLVERR 2'h2
`endif

/* File: logic/dtrp_pkg.sv */
// Types shared by the trace debug priority block.
// Assumes the constants header sits in the same folder.
package dtrp_pkg;
  `include "dtrp_consts.svh"
  // Core event inputs grouped as one carrier.
  typedef struct packed {
    logic [15:0] fetch_addr;
    logic fetch_valid;
    logic pipe_top_valid;
    logic [15:0] pipe_top_addr;
    logic irq_pending;
    logic [1:0] cof;
    logic [15:0] cur_addr;
  } dtrp_core_t;
endpackage

/* File: test/dtrp_core_model.sv */
// Behavioural model of the core side: program fetch, pipe top, interrupt and change-of-flow.
// Assumes the bench calls step from one process, one event at a time.
`timescale 1ns/1ps
module dtrp_core_model
  import dtrp_pkg::*;
(
  input wire logic aclk,
  output dtrp_core_t core
);
  // ----------------------------------------------------------------------
  // Event driver.
  // ----------------------------------------------------------------------
  // Event inputs; all strobes are quiet until the first event.
  initial begin
    core = '0;
  end
  // One event lasts a single cycle, then one idle cycle follows. In the idle cycle the
  // addresses show their inverse, so a stale value can never pass for a held one.
  task automatic step(input logic [15:0] fa, input logic fv, input logic pv,
      input logic irq, input logic [1:0] cof, input logic [15:0] ca);
    @(posedge aclk);
    core <= '{fa, fv, pv, fa, irq, cof, ca};
    @(posedge aclk);
    core <= '{~fa, 1'h0, 1'h0, ~fa, 1'h0, 2'h0, ~ca};
  endtask
endmodule

/* File: test/test_debug_trigger_reset_priority.sv */
// Self-checking bench for the trace trigger, interrupt priority and reset behaviour.
// Assumes the core model drives the event inputs and this bench acts as the host.
`timescale 1ns/1ps
module test_debug_trigger_reset_priority
  import dtrp_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals and reference model state.
  // ----------------------------------------------------------------------
  logic aclk = 1'h0; // Bus clock, 8 ns period.
  logic aresetn = 1'h0; // Synchronous reset, active low.
  logic por_n = 1'h0; // Power-on indication, active low.
  dtrp_core_t core; // Events from the core model.
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic break_request, mcu_reset_request, cpu_irq;
  logic [31:0] rd; // Data of the last read.
  logic m_arm, m_trig, m_begin; // Model: armed, triggered, begin-type run.
  logic [15:0] m_cmp, last_ca; // Model: comparator A and last core address.
  int failures = 0, num_checks = 0;
  int exp_q[$]; // Trace words the model expects, oldest first.
  always #4 aclk = ~aclk;
  dtrp_core_model core_m (.aclk, .core);
  dtrp_trace_ctrl uut (.aclk, .aresetn, .por_n, .core, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .break_request,
    .mcu_reset_request, .cpu_irq);
  // ----------------------------------------------------------------------
  // Reporting and host bus tasks.
  // ----------------------------------------------------------------------
  task automatic summarize();
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // A handshake that never completes ends the run at once.
  task automatic give_up();
    failures++;
    $display("ERROR handshake expected response seen none");
    summarize();
  endtask
  // Address and data go out together; each is released when it is taken.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (n < 50) begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'h0;
        rs = s_axi_bresp;
        return;
      end
    end
    give_up();
  endtask
  // Every read also confirms that no reset or interrupt request is leaving the block as the read completes.
  task automatic axi_read(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (n < 50) begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 1'h0;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        check("reset and irq requests", {30'h0, mcu_reset_request, cpu_irq}, 32'h0);
        return;
      end
    end
    give_up();
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp,
      input logic [31:0] mask = 32'hFFFFFFFF);
    axi_read(a);
    check(what, rd & mask, exp & mask);
  endtask
  // ----------------------------------------------------------------------
  // Reference model and scenario helpers.
  // ----------------------------------------------------------------------
  // Filler addresses stay away from every comparator value used here.
  function automatic logic [15:0] rnd();
    return 16'h3000 | 16'($urandom() & 32'h0FFF);
  endfunction
  // Status as the model sees it: armed flag and word count.
  function automatic logic [31:0] stat_exp();
    return {24'h0, m_arm, 3'h0, 4'(exp_q.size())};
  endfunction
  // One fetch event; the model stores flow changes only while a run is collecting.
  task automatic ev(input logic [15:0] fa, input logic irq, input logic [1:0] cof,
      input logic [15:0] ca);
    logic [15:0] prev;
    prev = ~last_ca;
    core_m.step(fa, 1'h1, 1'h0, irq, cof, ca);
    last_ca = ca;
    if (m_arm && m_begin) begin
      if (fa == m_cmp) m_trig = 1'h1;
      if (m_trig && cof[1]) exp_q.push_back(ca);
      if (m_trig && cof[0]) exp_q.push_back(prev - 16'h2);
      if (exp_q.size() == 8) m_arm = 1'h0;
    end else if (m_arm) begin
      if (cof[1] && !(fa == m_cmp && irq)) exp_q.push_back(ca);
      if (fa == m_cmp) m_arm = 1'h0;
    end
  endtask
  task automatic do_reset(input logic por);
    @(posedge aclk);
    aresetn <= 1'h0;
    por_n <= ~por;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    por_n <= 1'h1;
  endtask
  task automatic wait_break();
    int n;
    n = 0;
    while (n < 8 && break_request !== 1'h1) begin
      @(posedge aclk);
      n++;
    end
    check("break", {31'h0, break_request}, 32'h1);
  endtask
  // Trace words may only be read once the run has disarmed.
  task automatic drain();
    while (exp_q.size() > 0) rchk("trace", `DTRP_OFF_FIFO, exp_q.pop_front(), 32'hFFFF);
  endtask
  task automatic chk_defaults();
    rchk("main", `DTRP_OFF_MAIN, 32'hC0);
    rchk("trig", `DTRP_OFF_TRIG, 32'h40);
    rchk("cmpa", `DTRP_OFF_CMPA, 32'hFFFE);
  endtask
  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'hF13896FC));
    last_ca = 16'h0;
    do_reset(1'h1);
    chk_defaults();
    rchk("stat", `DTRP_OFF_STAT, 32'h80, 32'h8F);
    axi_read(8'h14);
    check("unmapped read", {rs, rd[29:0]}, {`DTRP_RESP_SLVERR, 30'h0});
    axi_write(8'h18, {16'h0, rnd()});
    check("unmapped write", {30'h0, rs}, {30'h0, `DTRP_RESP_SLVERR});
    // Begin run with break: interrupt on the trigger fetch, then fill to eight words.
    axi_write(`DTRP_OFF_MAIN, 32'hD0);
    {m_arm, m_begin, m_trig, m_cmp} = {3'b110, 16'hFFFE};
    exp_q.delete();
    ev(16'hFFFE, 1'h1, 2'b10, rnd());
    for (int i = 0; i < 6; i++) ev(rnd(), 1'h0, {i[0], ~i[0]}, rnd());
    rchk("stat", `DTRP_OFF_STAT, stat_exp(), 32'h8F);
    check("no early break", {31'h0, break_request}, 32'h0);
    ev(rnd(), 1'h0, 2'b10, rnd());
    ev(rnd(), 1'h0, 2'b10, rnd());
    wait_break();
    rchk("stat", `DTRP_OFF_STAT, stat_exp(), 32'h8F);
    drain();
    // End run on fetch: the coincident interrupt entry is not stored.
    axi_write(`DTRP_OFF_TRIG, 32'h00);
    axi_write(`DTRP_OFF_CMPA, 32'h1234);
    axi_write(`DTRP_OFF_MAIN, 32'hD0);
    {m_arm, m_begin, m_cmp} = {2'b10, 16'h1234};
    exp_q.delete();
    for (int i = 0; i < 3; i++) ev(rnd(), 1'h0, 2'b10, rnd());
    ev(16'h1234, 1'h1, 2'b10, rnd());
    // The break is a short pulse, so it is watched before the bus is used.
    wait_break();
    rchk("stat", `DTRP_OFF_STAT, stat_exp(), 32'h8F);
    // A reset after the end run keeps the results for the host.
    do_reset(1'h0);
    rchk("main", `DTRP_OFF_MAIN, 32'h80);
    rchk("trig", `DTRP_OFF_TRIG, 32'h00);
    rchk("cmpa", `DTRP_OFF_CMPA, 32'h1234);
    rchk("stat", `DTRP_OFF_STAT, stat_exp(), 32'h8F);
    check("break", {31'h0, break_request}, 32'h0);
    drain();
    // Opcode qualification: a pending interrupt wins over the pipe-top match.
    axi_write(`DTRP_OFF_TRIG, 32'h80);
    axi_write(`DTRP_OFF_CMPA, 32'h2000);
    axi_write(`DTRP_OFF_MAIN, 32'hC0);
    core_m.step(16'h2000, 1'h0, 1'h1, 1'h1, 2'h0, 16'h2000);
    rchk("stat", `DTRP_OFF_STAT, 32'h80, 32'h80);
    core_m.step(16'h2000, 1'h0, 1'h1, 1'h0, 2'h0, 16'h2000);
    rchk("stat", `DTRP_OFF_STAT, 32'h00, 32'h80);
    // A power-on reset replaces even an enabled end setup with the default run.
    do_reset(1'h1);
    chk_defaults();
    rchk("stat", `DTRP_OFF_STAT, 32'h80, 32'h8F);
    // Any other reset with a begin setting loads the default run.
    axi_write(`DTRP_OFF_CMPA, {16'h0, rnd()});
    axi_write(`DTRP_OFF_MAIN, 32'h90);
    axi_write(`DTRP_OFF_TRIG, 32'h40);
    do_reset(1'h0);
    chk_defaults();
    summarize();
  end
endmodule
